// *** shared/bfsp_pkg.sv ***
package bfsp_pkg;

   // ---------------------------------------------------------------
   // Address geometry
   // ---------------------------------------------------------------
   localparam int unsigned PC_W        = 14;
   localparam int unsigned CTR_TOP     = 13;
   localparam int unsigned IN_PAGE_TOP = 5;
   localparam int unsigned PTR_CTR_TOP = 14;
   localparam int unsigned PTR_PG_TOP  = 6;
   localparam int unsigned PTR_W       = 16;
   localparam int unsigned PAGE_WORDS  = 64;
   localparam int unsigned PAGE_W      = PC_W - IN_PAGE_TOP - 1;

   localparam logic [PC_W-1:0] NO_READ_WHILE_WRITE_REGION_START = 14'h3800;
   localparam logic [PC_W-1:0] BOOT_11    = 14'h3F00;
   localparam logic [PC_W-1:0] BOOT_10    = 14'h3E00;
   localparam logic [PC_W-1:0] BOOT_01    = 14'h3C00;
   localparam logic [PC_W-1:0] BOOT_00    = 14'h3800;

   // ---------------------------------------------------------------
   // Control bit positions and timing
   // ---------------------------------------------------------------
   localparam int unsigned CTL_W      = 8;
   localparam int unsigned STORE_EN   = 0;
   localparam int unsigned PG_ERASE   = 1;
   localparam int unsigned PG_WRITE   = 2;
   localparam int unsigned LOCK_SET   = 3;
   localparam int unsigned REENABLE   = 4;
   localparam int unsigned WIN_CYC    = 4;
   localparam int unsigned CLK_KHZ    = 200_000;
   localparam int unsigned OP_MIN_US  = 3_700;
   localparam int unsigned OP_MAX_US  = 4_500;
   localparam int unsigned OP_CYC     = (OP_MIN_US * (CLK_KHZ / 1000) + 0);
   localparam int unsigned TMR_W      = 20;

   typedef enum logic [1:0] {BFSP_NONE, BFSP_ERASE, BFSP_WRITE, BFSP_LOCK} bfsp_op_t;

   typedef struct packed {
      logic [PAGE_W-1:0]      page;
      logic [IN_PAGE_TOP:0]   word;
      logic                   byteSel;
   } bfsp_ptr_t;

   typedef struct packed {
      logic              valid;
      logic [PC_W-1:0]   addr;
   } bfsp_fetch_t;

endpackage

// *** design/bfsp_op_timer.sv ***
// Counts one timed flash operation; done pulses in the same cycle that busy drops
module bfsp_op_timer #(
   parameter int unsigned OP_CYCLES = bfsp_pkg::OP_CYC
) (
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic start,
   output logic      busy,
   output logic      done
);
   logic [bfsp_pkg::TMR_W-1:0] cnt_ff;
   logic [bfsp_pkg::TMR_W-1:0] nxt_cnt;
   logic                       busy_ff;
   logic                       nxt_busy;
   logic                       done_ff;
   logic                       nxt_done;

   always_comb begin
      nxt_cnt  = cnt_ff;
      nxt_busy = busy_ff;
      nxt_done = 1'b0;
      if (start && !busy_ff) begin
         nxt_busy = 1'b1;
         nxt_cnt  = bfsp_pkg::TMR_W'(OP_CYCLES - 1);
      end else if (busy_ff) begin
         if (cnt_ff == '0) begin
            nxt_busy = 1'b0;
            nxt_done = 1'b1;
         end else begin
            nxt_cnt = cnt_ff - 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt_ff  <= '0;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         cnt_ff  <= nxt_cnt;
         busy_ff <= nxt_busy;
         done_ff <= nxt_done;
      end
   end

   assign busy = busy_ff;
   assign done = done_ff;
endmodule

// *** design/bfsp_flash_seq.sv ***
// Behaviour
// - Flash operations last 3.7 to 4.5 ms
// - Boot size selects boot section start
// - Below 3800 read-while-write, above not
// - Program counter is fourteen bits wide
// - Sixty-four word pages, word from PC[5:0]
// - Page number from pointer bits 14..7
// - Buffer word index from pointer bits 6..1
// - Pointer bit 15 ignored, bit 0 byte
// - Busy: only no-read-while-write region readable
// - Store must follow control write within four
// - Busy flag cleared only by re-enable
module bfsp_flash_seq #(
   parameter int unsigned OP_CYCLES = bfsp_pkg::OP_CYC
) (
   input  wire logic                          clk,
   input  wire logic                          sys_rst,
   input  wire logic [1:0]                    bootSize,
   input  wire logic                          ctlWr,
   input  wire logic [bfsp_pkg::CTL_W-1:0]    ctlWdata,
   input  wire logic                          storeExec,
   input  wire logic [bfsp_pkg::PTR_W-1:0]    ptr,
   input  wire logic                          eepromWriteActive,
   input  wire bfsp_pkg::bfsp_fetch_t          fetch,
   output logic [bfsp_pkg::CTL_W-1:0]         ctlRdata,
   output logic [bfsp_pkg::PC_W-1:0]          bootStart,
   output logic                               fetchGrant,
   output logic                               fetchBlocked,
   output logic                               bufLoad,
   output logic [bfsp_pkg::IN_PAGE_TOP:0]     bufWord,
   output logic                               flashOpStart,
   output bfsp_pkg::bfsp_op_t                 flashOp,
   output logic [bfsp_pkg::PAGE_W-1:0]        flashPage,
   output logic                               byteSel
);
   // ---------------------------------------------------------------
   // Control state
   // ---------------------------------------------------------------
   logic [bfsp_pkg::CTL_W-1:0] ctl_ff, nxt_ctl;
   logic [2:0]                 win_ff, nxt_win;
   logic                       rwwBusy_ff, nxt_rwwBusy;
   bfsp_pkg::bfsp_op_t          op_ff, nxt_op;
   logic [bfsp_pkg::PAGE_W-1:0] page_ff, nxt_page;
   logic                       start_ff, nxt_start;
   logic                       load_ff, nxt_load;
   logic [bfsp_pkg::IN_PAGE_TOP:0] word_ff, nxt_word;
   logic                       byte_ff, nxt_byte;
   logic                       grant_ff, nxt_grant;
   logic                       blocked_ff, nxt_blocked;
   logic [bfsp_pkg::PC_W-1:0]  boot_ff, nxt_boot;
   logic                       tmrBusy, tmrDone;
   bfsp_pkg::bfsp_ptr_t         pf;
   logic                       inNrww;

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   // Pointer bit 15 never reaches the decode
   assign pf     = ptr[bfsp_pkg::PTR_CTR_TOP:0];
   assign inNrww = fetch.addr >= bfsp_pkg::NO_READ_WHILE_WRITE_REGION_START;

   bfsp_op_timer #(.OP_CYCLES(OP_CYCLES)) u_tmr (
      .clk     (clk),
      .sys_rst (sys_rst),
      .start   (nxt_start),
      .busy    (tmrBusy),
      .done    (tmrDone)
   );

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      nxt_ctl     = ctl_ff;
      nxt_win     = (win_ff != '0) ? win_ff - 3'd1 : win_ff;
      nxt_rwwBusy = rwwBusy_ff;
      nxt_op      = op_ff;
      nxt_page    = page_ff;
      nxt_start   = 1'b0;
      nxt_load    = 1'b0;
      nxt_word    = word_ff;
      nxt_byte    = pf.byteSel;
      unique case (bootSize)
         2'b11:   nxt_boot = bfsp_pkg::BOOT_11;
         2'b10:   nxt_boot = bfsp_pkg::BOOT_10;
         2'b01:   nxt_boot = bfsp_pkg::BOOT_01;
         default: nxt_boot = bfsp_pkg::BOOT_00;
      endcase
      // Window expiry discards an armed request
      if (win_ff == 3'd1 && !storeExec && !tmrBusy) begin
         nxt_ctl[bfsp_pkg::STORE_EN] = 1'b0;
         nxt_ctl[bfsp_pkg::PG_ERASE] = 1'b0;
         nxt_ctl[bfsp_pkg::PG_WRITE] = 1'b0;
         nxt_ctl[bfsp_pkg::LOCK_SET] = 1'b0;
         nxt_ctl[bfsp_pkg::REENABLE] = 1'b0;
      end
      // Completion clears first so a same-cycle control write stands
      if (tmrDone) begin
         nxt_ctl = '0;
         nxt_op  = bfsp_pkg::BFSP_NONE;
      end
      if (ctlWr && !tmrBusy && !eepromWriteActive) begin
         nxt_ctl = ctlWdata & 8'h1F;
         nxt_win = (ctlWdata[bfsp_pkg::STORE_EN]) ? 3'(bfsp_pkg::WIN_CYC) : 3'd0;
      end else if (storeExec && win_ff != '0 && ctl_ff[bfsp_pkg::STORE_EN]) begin
         nxt_win  = '0;
         nxt_page = pf.page;
         if (ctl_ff[bfsp_pkg::PG_ERASE] || ctl_ff[bfsp_pkg::PG_WRITE]
             || ctl_ff[bfsp_pkg::LOCK_SET]) begin
            nxt_start = 1'b1;
            nxt_op    = ctl_ff[bfsp_pkg::PG_ERASE] ? bfsp_pkg::BFSP_ERASE :
                        ctl_ff[bfsp_pkg::PG_WRITE] ? bfsp_pkg::BFSP_WRITE :
                                                     bfsp_pkg::BFSP_LOCK;
            if (!ctl_ff[bfsp_pkg::LOCK_SET])
               nxt_rwwBusy = 1'b1;
         end else if (ctl_ff[bfsp_pkg::REENABLE]) begin
            if (!tmrBusy)
               nxt_rwwBusy = 1'b0;
            nxt_ctl = '0;
         end else begin
            nxt_load = 1'b1;
            nxt_word = pf.word;
            nxt_ctl  = '0;
         end
      end
      nxt_ctl[bfsp_pkg::CTL_W-2] = nxt_rwwBusy;
      // Region blocking while the busy flag is set
      nxt_grant   = fetch.valid && (!nxt_rwwBusy || inNrww);
      nxt_blocked = fetch.valid && nxt_rwwBusy && !inNrww;
   end

   // ---------------------------------------------------------------
   // State registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctl_ff     <= '0;
         win_ff     <= '0;
         rwwBusy_ff <= 1'b0;
         op_ff      <= bfsp_pkg::BFSP_NONE;
         page_ff    <= '0;
         start_ff   <= 1'b0;
         load_ff    <= 1'b0;
         word_ff    <= '0;
         byte_ff    <= 1'b0;
         grant_ff   <= 1'b0;
         blocked_ff <= 1'b0;
         boot_ff    <= bfsp_pkg::BOOT_00;
      end else begin
         ctl_ff     <= nxt_ctl;
         win_ff     <= nxt_win;
         rwwBusy_ff <= nxt_rwwBusy;
         op_ff      <= nxt_op;
         page_ff    <= nxt_page;
         start_ff   <= nxt_start;
         load_ff    <= nxt_load;
         word_ff    <= nxt_word;
         byte_ff    <= nxt_byte;
         grant_ff   <= nxt_grant;
         blocked_ff <= nxt_blocked;
         boot_ff    <= nxt_boot;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign ctlRdata     = ctl_ff;
   assign bootStart    = boot_ff;
   assign fetchGrant   = grant_ff;
   assign fetchBlocked = blocked_ff;
   assign bufLoad      = load_ff;
   assign bufWord      = word_ff;
   assign flashOpStart = start_ff;
   assign flashOp      = op_ff;
   assign flashPage    = page_ff;
   assign byteSel      = byte_ff;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   a_busy_blocks_rww: assert property (@(posedge clk) disable iff (sys_rst)
      (fetch.valid && nxt_rwwBusy && !inNrww) |=> (fetchBlocked && !fetchGrant))
      else $error("busy region fetch not blocked");
   a_no_read_while_write_region_readable: assert property (@(posedge clk) disable iff (sys_rst)
      (fetch.valid && inNrww) |=> fetchGrant)
      else $error("no-read-while-write fetch refused");
   a_store_en_clear: assert property (@(posedge clk) disable iff (sys_rst)
      (tmrDone && !ctlWr) |=> !ctlRdata[bfsp_pkg::STORE_EN])
      else $error("store enable not cleared at end");
   a_busy_holds: assert property (@(posedge clk) disable iff (sys_rst)
      (rwwBusy_ff && !(storeExec && ctl_ff[bfsp_pkg::REENABLE])) |=> rwwBusy_ff)
      else $error("busy flag cleared without re-enable");
   a_window_expire: assert property (@(posedge clk) disable iff (sys_rst)
      (win_ff == 3'd1 && !storeExec && !ctlWr && !tmrBusy) |=> !ctlRdata[bfsp_pkg::STORE_EN])
      else $error("request kept past window");
   a_op_page_map: assert property (@(posedge clk) disable iff (sys_rst)
      nxt_start |=> (flashOpStart && flashPage == $past(ptr[14:7])))
      else $error("page not taken from pointer");
   a_buf_word_map: assert property (@(posedge clk) disable iff (sys_rst)
      nxt_load |=> (bufLoad && bufWord == $past(ptr[6:1])))
      else $error("word index not from pointer");
   a_boot_map: assert property (@(posedge clk) disable iff (sys_rst)
      (bootSize == 2'b11) |=> (bootStart == bfsp_pkg::BOOT_11))
      else $error("boot start wrong for size 11");
   a_boot_512_words: assert property (@(posedge clk) disable iff (sys_rst)
      (bootSize == 2'b10) |=> (bootStart == bfsp_pkg::BOOT_10))
      else $error("boot start wrong for size 10");
   a_boot_1024_words: assert property (@(posedge clk) disable iff (sys_rst)
      (bootSize == 2'b01) |=> (bootStart == bfsp_pkg::BOOT_01))
      else $error("boot start wrong for size 01");
   a_boot_2048_words: assert property (@(posedge clk) disable iff (sys_rst)
      (bootSize == 2'b00) |=> (bootStart == bfsp_pkg::BOOT_00))
      else $error("boot start wrong for size 00");
   a_byte_sel_map: assert property (@(posedge clk) disable iff (sys_rst)
      !sys_rst |=> (byteSel == $past(ptr[0])))
      else $error("byte select not from pointer bit zero");
   a_reenable_clears_busy: assert property (@(posedge clk) disable iff (sys_rst)
      (storeExec && win_ff != '0 && ctl_ff[bfsp_pkg::STORE_EN] && ctl_ff[bfsp_pkg::REENABLE]
       && !ctl_ff[bfsp_pkg::PG_ERASE] && !ctl_ff[bfsp_pkg::PG_WRITE]
       && !ctl_ff[bfsp_pkg::LOCK_SET] && !ctlWr && !tmrBusy) |=> !ctlRdata[bfsp_pkg::CTL_W-2])
      else $error("re-enable did not clear busy flag");
endmodule

// *** verif/bfsp_cpu_model.sv ***
module bfsp_cpu_model (
   input  wire logic        clk,
   input  wire logic [7:0]  ctlRdata,
   input  wire logic        eepromWriteActive,
   output logic             ctlWr,
   output logic [7:0]       ctlWdata,
   output logic             storeExec,
   output logic [15:0]      ptr
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      ctlWr     = 1'b0;
      ctlWdata  = 8'h00;
      storeExec = 1'b0;
      ptr       = 16'h0000;
   end
   // Control write, then the store gap cycles later; gap above 4 misses the window
   task automatic issue(input logic [7:0] cmd, input logic [15:0] p, input int gap);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while ((ctlRdata[0] !== 1'b0 || eepromWriteActive !== 1'b0) && n < 5000);
      @(posedge clk);
      ctlWr    <= 1'b1;
      ctlWdata <= cmd;
      @(posedge clk);
      ctlWr    <= 1'b0;
      ctlWdata <= ~cmd;
      repeat (gap - 1) @(posedge clk);
      storeExec <= 1'b1;
      ptr       <= p;
      @(posedge clk);
      storeExec <= 1'b0;
      ptr       <= ~p;
   endtask
   // Repeats the re-enable command until the busy flag drops
   task automatic reopen();
      int n;
      n = 0;
      while (ctlRdata[6] !== 1'b0 && n < 8) begin
         issue(8'h11, 16'h0000, 1);
         repeat (2) @(posedge clk);
         #1;
         n++;
      end
   endtask
endmodule

// *** verif/boot_flash_self_program_map_bench.sv ***
module boot_flash_self_program_map_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int OPC = 20;
   logic clk, sysRst, eepromWriteActive, ctlWr, storeExec;
   logic fetchGrant, fetchBlocked, bufLoad, flashOpStart, byteSel, lastByte;
   logic [1:0]  bootSize;
   logic [7:0]  ctlWdata, ctlRdata, lastPage;
   logic [15:0] ptr;
   logic [13:0] bootStart;
   logic [5:0]  bufWord, lastWord;
   bfsp_pkg::bfsp_fetch_t fetch;
   bfsp_pkg::bfsp_op_t    flashOp, lastOp;
   int seed, bad_count, samples_checked, opCount, loadCount;
   logic [15:0] p;

   bfsp_flash_seq #(.OP_CYCLES(OPC)) dut (.clk(clk), .sys_rst(sysRst), .bootSize(bootSize),
      .ctlWr(ctlWr), .ctlWdata(ctlWdata), .storeExec(storeExec), .ptr(ptr),
      .eepromWriteActive(eepromWriteActive), .fetch(fetch), .ctlRdata(ctlRdata),
      .bootStart(bootStart), .fetchGrant(fetchGrant), .fetchBlocked(fetchBlocked),
      .bufLoad(bufLoad), .bufWord(bufWord), .flashOpStart(flashOpStart),
      .flashOp(flashOp), .flashPage(lastPage), .byteSel(byteSel));
   bfsp_cpu_model cpu (.clk(clk), .ctlRdata(ctlRdata), .eepromWriteActive(eepromWriteActive),
      .ctlWr(ctlWr), .ctlWdata(ctlWdata), .storeExec(storeExec), .ptr(ptr));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Captures each one-cycle pulse with what travels beside it
   always @(posedge clk) begin
      if (flashOpStart === 1'b1) begin
         opCount++;
         lastOp   = flashOp;
         lastByte = byteSel;
      end
      if (bufLoad === 1'b1) begin
         loadCount++;
         lastWord = bufWord;
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      if (bad_count == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   function automatic logic [13:0] rww_addr();
      return 14'($unsigned($random(seed)) % 32'h0000_3800);
   endfunction
   task automatic probe(input logic [13:0] a, input logic busy);
      @(posedge clk);
      fetch <= '{valid: 1'b1, addr: a};
      @(posedge clk);
      fetch.valid <= 1'b0;
      #1;
      check(fetchBlocked, busy && a < 14'h3800);
      check(fetchGrant, !(busy && a < 14'h3800));
   endtask
   task automatic run_op(input logic [7:0] cmd, input logic [15:0] v, input int gap);
      int ops, loads, n;
      logic [1:0] op;
      logic busy;
      time t0;
      op    = cmd[1] ? 2'd1 : cmd[2] ? 2'd2 : cmd[3] ? 2'd3 : 2'd0;
      busy  = cmd[1] | cmd[2];
      ops   = opCount;
      loads = loadCount;
      cpu.issue(cmd, v, gap);
      @(posedge clk);
      #1;
      t0 = $time;
      n  = (gap <= 4) ? 1 : 0;
      check(byteSel, !v[0]);
      check(16'(opCount - ops), (op != 2'd0) ? 16'(n) : 16'h0000);
      check(16'(loadCount - loads), (op == 2'd0) ? 16'(n) : 16'h0000);
      if (n == 0) begin
         check(ctlRdata, 16'h0000);
         return;
      end
      if (op == 2'd0) begin
         check(lastWord, v[6:1]);
         return;
      end
      check(lastOp, op);
      check(lastPage, v[14:7]);
      check(lastByte, 1'b0);
      check(ctlRdata[6], busy);
      probe(rww_addr(), busy);
      probe(14'h37FF, busy);
      probe(14'h3800, busy);
      while (ctlRdata[0] !== 1'b0 && ($time - t0) < 2000) begin
         @(posedge clk);
         #1;
      end
      check((($time - t0) / 5) inside {[OPC - 1:OPC + 4]}, 1'b1);
      check(ctlRdata[6], busy);
      cpu.reopen();
      check(ctlRdata[6], 1'b0);
      probe(rww_addr(), 1'b0);
   endtask

   initial begin
      repeat (5000) @(posedge clk);
      bad_count++;
      wrap_up();
   end
   initial begin
      seed = 98311;
      sysRst = 1'b1;
      bootSize = 2'b00;
      eepromWriteActive = 1'b0;
      fetch = '{valid: 1'b0, addr: 14'h0000};
      repeat (5) @(posedge clk);
      sysRst <= 1'b0;
      @(posedge clk);
      #1;
      check(ctlRdata, 16'h0000);
      check(bootStart, 14'h3800);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         bootSize <= 2'(i);
         repeat (2) @(posedge clk);
         #1;
         check(bootStart, 16'h4000 - (16'h0100 << (3 - i)));
      end
      for (int k = 0; k < 3; k++) begin
         p = 16'($random(seed));
         run_op(8'h01, p & 16'hFFFE, 1 + k);
         run_op(8'h03, p & 16'hFF80, 1 + k);
         run_op(8'h05, p & 16'hFF80, 3 - k);
      end
      run_op(8'h09, 16'h0000, 4);
      run_op(8'h03, 16'h1080, 7);
      @(posedge clk);
      eepromWriteActive <= 1'b1;
      fork
         begin
            repeat (10) @(posedge clk);
            eepromWriteActive <= 1'b0;
         end
      join_none
      run_op(8'h05, 16'hBF80, 2);
      wrap_up();
   end
endmodule
